// ### core/fpu_exception_reporting.sv
// Fault detection, error pin and register file of the floating-point unit
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns

module fpu_exception_reporting
   import fpu_exc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        task_switched_flag,
   input  wire logic        emulation_flag,
   input  wire logic        align_check_en,
   input  wire logic [1:0]  cpl,
   input  wire logic        v86_mode,
   input  wire logic        issue_valid,
   input  wire op_kind_t    issue_kind,
   input  wire logic        issue_legal,
   input  wire logic [15:0] issue_cs,
   input  wire logic [31:0] issue_prefix_ip,
   input  wire logic        issue_misaligned,
   input  wire logic        issue_stack_part,
   input  wire logic        issue_beyond_limit,
   input  wire logic        issue_seg_overrun,
   input  wire logic        issue_denormal,
   output logic             issue_ready,
   output logic             exec_go,
   output logic             normalize_req,
   output logic             rem_round_nearest,
   output logic             fault_valid,
   output logic [7:0]       fault_vector,
   output logic             abort_out,
   output logic             env_probe_req,
   output logic             env_probe_last,
   input  wire logic        env_probe_ack,
   input  wire logic        env_probe_fault,
   output logic             env_commit,
   input  wire logic        done_valid,
   input  wire logic        done_unmasked_exc,
   input  wire logic        done_inexact,
   input  wire logic        done_underflow,
   input  wire logic        done_uflow_loss,
   input  wire logic        done_second_frac,
   input  wire logic [2:0]  done_quotient,
   output logic             res_invalid,
   output logic             res_underflow,
   output logic             res_precision,
   output logic             scale_factor_zero,
   output logic             cond_flag_zero,
   output logic             cond_flag_one,
   output logic             cond_flag_three,
   input  wire logic        ignore_numeric_error_in,
   output logic             fp_error_out
);

   // ==========================================================
   // Register file and internal state
   logic [31:0]        ctrl;
   logic [ST_BITS-1:0] status;
   logic [ST_BITS-1:0] mask;
   logic [15:0]        saved_cs;
   logic [31:0]        saved_ip;
   logic [7:0]         last_vec;
   logic [15:0]        cur_cs;
   logic [31:0]        cur_ip;
   op_kind_t           cur_kind;
   logic               cur_denorm;
   env_state_t         env_state;
   logic               ign_meta;
   logic               ign_sync;

   logic               setup;
   logic               wr_acc;
   logic               hit;
   logic [31:0]        rd_val;
   logic [ST_BITS-1:0] ev_set;
   logic [ST_BITS-1:0] w1c;
   logic               take;
   logic               f_dev_na;
   logic               f_bad_op;
   logic               f_err_flt;
   logic               f_limit;
   logic               f_align;
   logic               f_any;
   logic [7:0]         next_vec;
   logic               denorm_class;

   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & pready & pwrite;

   // ==========================================================
   // Read decode; unmapped offsets answer with an error
   always_comb begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL:     rd_val = ctrl;
         OFS_STATUS:   rd_val = {25'h0, status};
         OFS_MASK:     rd_val = {25'h0, mask};
         OFS_SAVED_CS: rd_val = {16'h0, saved_cs};
         OFS_SAVED_IP: rd_val = saved_ip;
         OFS_LAST_VEC: rd_val = {24'h0, last_vec};
         default:      hit    = 1'b0;
      endcase
   end

   // Answer prepared in setup, so the access phase ends at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         if (setup & ~pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   // Control and mask writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         mask <= MASK_RESET;
      end else if (wr_acc) begin
         if (paddr == OFS_CTRL) begin
            ctrl <= pwdata;
         end
         if (paddr == OFS_MASK) begin
            mask <= pwdata[ST_BITS-1:0];
         end
      end
   end

   // ==========================================================
   // Error-ignore pin arrives from outside, two flops first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ign_meta <= 1'b0;
         ign_sync <= 1'b0;
      end else begin
         ign_meta <= ignore_numeric_error_in;
         ign_sync <= ign_meta;
      end
   end

   // ==========================================================
   // Fault priority: device-not-available, opcode, error, limit, alignment
   assign take = issue_valid & issue_ready;
   assign f_dev_na = task_switched_flag | emulation_flag;
   assign f_bad_op = ~f_dev_na & ~issue_legal;
   // Undefined opcode wins before the error check is made
   assign f_err_flt = ~f_dev_na & issue_legal & status[ST_ERR_PENDING] & ~ign_sync;
   assign f_limit = ~f_dev_na & issue_legal & ~f_err_flt & issue_beyond_limit;
   assign f_align = ~f_dev_na & issue_legal & ~f_err_flt & ~issue_beyond_limit & align_check_en
                 & (cpl == CPL_USER) & issue_misaligned & ~issue_stack_part;
   assign f_any = f_dev_na | f_bad_op | f_err_flt | f_limit | f_align;

   // Vector 16 outside the virtual mode; a monitor picks its own there
   always_comb begin
      next_vec = VEC_ALIGN_CHECK;
      if (f_dev_na) begin
         next_vec = VEC_DEVICE_NA;
      end else if (f_bad_op) begin
         next_vec = VEC_INVALID_OPCODE;
      end else if (f_err_flt) begin
         next_vec = v86_mode ? ctrl[CTRL_V86VEC_LSB +: 8] : VEC_FP_ERROR;
      end else if (f_limit) begin
         next_vec = VEC_GEN_PROT;
      end
   end

   // Fault, go and abort pulses; overrun never gets its own vector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_valid   <= 1'b0;
         fault_vector  <= 8'h00;
         exec_go       <= 1'b0;
         abort_out     <= 1'b0;
         normalize_req <= 1'b0;
      end else begin
         fault_valid   <= take & f_any;
         exec_go       <= take & ~f_any & ~issue_seg_overrun & (issue_kind != OP_LDENV);
         abort_out     <= (take & ~f_any & issue_seg_overrun)
                          | (env_state != ENV_IDLE & env_probe_fault);
         normalize_req <= take & ~f_any & issue_denormal & denorm_class;
         if (take & f_any) begin
            fault_vector <= next_vec;
         end
      end
   end

   assign denorm_class = (issue_kind == OP_SQRT) | (issue_kind == OP_DIV)
                         | (issue_kind == OP_PREM) | (issue_kind == OP_PREM1)
                         | (issue_kind == OP_CONV);

   // ==========================================================
   // Instruction context held until its completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_cs            <= 16'h0000;
         cur_ip            <= 32'h0000_0000;
         cur_kind          <= OP_OTHER;
         cur_denorm        <= 1'b0;
         rem_round_nearest <= 1'b0;
      end else if (take) begin
         cur_cs            <= issue_cs;
         cur_ip            <= issue_prefix_ip;
         cur_kind          <= issue_kind;
         cur_denorm        <= issue_denormal & denorm_class;
         rem_round_nearest <= (issue_kind == OP_PREM1);
      end
   end

   // Saved pointers: faults use the issue, errors use the finished one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         saved_cs <= 16'h0000;
         saved_ip <= 32'h0000_0000;
         last_vec <= 8'h00;
      end else if (take & f_any) begin
         saved_cs <= issue_cs;
         saved_ip <= issue_prefix_ip;
         last_vec <= next_vec;
      end else if (done_valid & done_unmasked_exc) begin
         saved_cs <= cur_cs;
         saved_ip <= cur_ip;
      end
   end

   // ==========================================================
   // Environment load probes both ends before any state changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         env_state <= ENV_IDLE;
      end else begin
         unique case (env_state)
            ENV_IDLE: begin
               if (take & ~f_any & ~issue_seg_overrun & (issue_kind == OP_LDENV)) begin
                  env_state <= ENV_FIRST;
               end
            end
            ENV_FIRST: begin
               if (env_probe_fault) begin
                  env_state <= ENV_IDLE;
               end else if (env_probe_ack) begin
                  env_state <= ENV_LAST;
               end
            end
            ENV_LAST: begin
               if (env_probe_fault) begin
                  env_state <= ENV_IDLE;
               end else if (env_probe_ack) begin
                  env_state <= ENV_LOAD;
               end
            end
            ENV_LOAD: env_state <= ENV_IDLE;
         endcase
      end
   end

   // Probe strobes and commit pulse come from the state flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         env_probe_req  <= 1'b0;
         env_probe_last <= 1'b0;
         env_commit     <= 1'b0;
         issue_ready    <= 1'b0;
      end else begin
         env_probe_req  <= 1'b0;
         env_probe_last <= 1'b0;
         env_commit     <= (env_state == ENV_LAST) & env_probe_ack & ~env_probe_fault;
         issue_ready    <= (env_state == ENV_IDLE) & ~(take & issue_kind == OP_LDENV)
                           | (env_state == ENV_LOAD) | env_probe_fault;
         if (env_state == ENV_FIRST & ~env_probe_ack & ~env_probe_fault) begin
            env_probe_req <= 1'b1;
         end
         if (env_state == ENV_LAST & ~env_probe_ack & ~env_probe_fault) begin
            env_probe_req  <= 1'b1;
            env_probe_last <= 1'b1;
         end
         if (take & ~f_any & ~issue_seg_overrun & (issue_kind == OP_LDENV)) begin
            env_probe_req <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Result flags of a finished operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_invalid       <= 1'b0;
         res_underflow     <= 1'b0;
         res_precision     <= 1'b0;
         scale_factor_zero <= 1'b0;
         cond_flag_zero    <= 1'b0;
         cond_flag_one     <= 1'b0;
         cond_flag_three   <= 1'b0;
      end else if (done_valid) begin
         // A normalized denormal is never an invalid operand
         res_invalid   <= 1'b0;
         res_underflow <= done_underflow | (cur_denorm & done_underflow);
         res_precision <= done_inexact
                          | ((cur_kind == OP_SCALE) & done_uflow_loss);
         scale_factor_zero <= (cur_kind == OP_SCALE) & done_second_frac;
         if (cur_kind == OP_PREM | cur_kind == OP_PREM1) begin
            cond_flag_zero  <= done_quotient[2];
            cond_flag_three <= done_quotient[1];
            cond_flag_one   <= done_quotient[0];
         end
      end
   end

   // ==========================================================
   // Sticky status; a new event beats a same-cycle clear
   always_comb begin
      ev_set                 = '0;
      ev_set[ST_ERR_PENDING] = done_valid & done_unmasked_exc;
      ev_set[ST_INV_OPCODE]  = take & f_bad_op;
      ev_set[ST_DEV_NA]      = take & f_dev_na;
      ev_set[ST_GEN_PROT]    = take & f_limit;
      ev_set[ST_ALIGN]       = take & f_align;
      ev_set[ST_FP_FAULT]    = take & f_err_flt;
      ev_set[ST_ABORT]       = (take & ~f_any & issue_seg_overrun)
                               | (env_state != ENV_IDLE & env_probe_fault);
      w1c = (wr_acc & paddr == OFS_STATUS) ? pwdata[ST_BITS-1:0] : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status <= (status & ~w1c) | ev_set;
      end
   end

   // Pin and interrupt lag the status by one flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fp_error_out <= 1'b0;
         irq          <= 1'b0;
      end else begin
         fp_error_out <= status[ST_ERR_PENDING] & ctrl[CTRL_LEGACY_BIT];
         irq          <= |(status & mask);
      end
   end

   // ==========================================================
   // Checks
   sequence s_err_done;
      done_valid & done_unmasked_exc & ctrl[CTRL_LEGACY_BIT] & ~wr_acc;
   endsequence

   sequence s_dev_na_issue;
      take & (task_switched_flag | emulation_flag);
   endsequence

   chk_err_pin_rise: assert property (@(posedge pclk) disable iff (!presetn)
      s_err_done |-> ##2 fp_error_out)
      else $error("error pin not raised two cycles after exception");

   chk_err_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
      fp_error_out & ~$past(wr_acc) & ~wr_acc & ctrl[CTRL_LEGACY_BIT] |=> fp_error_out)
      else $error("error pin dropped without a clear");

   chk_dev_na_vector: assert property (@(posedge pclk) disable iff (!presetn)
      s_dev_na_issue |=> fault_valid & fault_vector == VEC_DEVICE_NA)
      else $error("device-not-available fault not on vector 7");

   chk_bad_op_vector: assert property (@(posedge pclk) disable iff (!presetn)
      take & ~f_dev_na & ~issue_legal |=> fault_valid & fault_vector == VEC_INVALID_OPCODE)
      else $error("undefined opcode not on vector 6");

   chk_block_next: assert property (@(posedge pclk) disable iff (!presetn)
      take & issue_legal & status[ST_ERR_PENDING] & ~ign_sync |=> ~exec_go & fault_valid)
      else $error("instruction ran with an error pending");

   chk_limit_vector: assert property (@(posedge pclk) disable iff (!presetn)
      take & ~f_dev_na & issue_legal & ~f_err_flt & issue_beyond_limit
      |=> fault_vector == VEC_GEN_PROT)
      else $error("segment limit fault not on vector 13");

   chk_no_commit_early: assert property (@(posedge pclk) disable iff (!presetn)
      env_commit |-> $past(env_state) == ENV_LAST & $past(env_probe_ack))
      else $error("environment committed before last probe");

   chk_overrun_abort: assert property (@(posedge pclk) disable iff (!presetn)
      take & ~f_any & issue_seg_overrun |=> abort_out & ~fault_valid & ~exec_go)
      else $error("segment overrun not aborted");

   chk_quot_flags: assert property (@(posedge pclk) disable iff (!presetn)
      done_valid & cur_kind == OP_PREM
      |=> {cond_flag_zero, cond_flag_three, cond_flag_one} == $past(done_quotient))
      else $error("quotient bits misplaced");

   chk_saved_ip: assert property (@(posedge pclk) disable iff (!presetn)
      take & f_any |=> saved_ip == $past(issue_prefix_ip))
      else $error("saved pointer not the prefix address");

endmodule

// ### core/fpu_exc_pkg.sv
// Constants, register map and types of the floating-point exception unit
package fpu_exc_pkg;

   // ==========================================================
   // Fault vectors
   localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
   localparam logic [7:0] VEC_DEVICE_NA      = 8'h07;
   localparam logic [7:0] VEC_GEN_PROT       = 8'h0D;
   localparam logic [7:0] VEC_FP_ERROR       = 8'h10;
   localparam logic [7:0] VEC_ALIGN_CHECK    = 8'h11;
   localparam logic [1:0] CPL_USER           = 2'h3;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_MASK     = 8'h08;
   localparam logic [7:0] OFS_SAVED_CS = 8'h0C;
   localparam logic [7:0] OFS_SAVED_IP = 8'h10;
   localparam logic [7:0] OFS_LAST_VEC = 8'h14;

   // Control fields and reset value
   localparam int         CTRL_LEGACY_BIT = 0;
   localparam int         CTRL_V86VEC_LSB = 8;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_1000;

   // Status and mask bit positions
   localparam int ST_ERR_PENDING = 0;
   localparam int ST_INV_OPCODE  = 1;
   localparam int ST_DEV_NA      = 2;
   localparam int ST_GEN_PROT    = 3;
   localparam int ST_ALIGN       = 4;
   localparam int ST_FP_FAULT    = 5;
   localparam int ST_ABORT       = 6;
   localparam int ST_BITS        = 7;
   localparam logic [ST_BITS-1:0] MASK_RESET = 7'h00;

   // ==========================================================
   // Operation classes presented with each instruction
   typedef enum logic [2:0] {
      OP_OTHER  = 3'h0,
      OP_SQRT   = 3'h1,
      OP_DIV    = 3'h2,
      OP_PREM   = 3'h3,
      OP_PREM1  = 3'h4,
      OP_CONV   = 3'h5,
      OP_SCALE  = 3'h6,
      OP_LDENV  = 3'h7
   } op_kind_t;

   // Environment-load probe sequence, Gray coded
   typedef enum logic [1:0] {
      ENV_IDLE  = 2'b00,
      ENV_FIRST = 2'b01,
      ENV_LAST  = 2'b11,
      ENV_LOAD  = 2'b10
   } env_state_t;

endpackage

// ### tb/irq_controller_model.sv
// Behavioural interrupt controller fed by the floating-point error pin
`timescale 1ns/1ns

module irq_controller_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic fp_error_out,
   output logic      maskable_irq_in
);
   // ==========================================================
   // Request stage
   // Level input, one flop of latency like a real controller's input stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maskable_irq_in <= 1'b0;
      end else begin
         maskable_irq_in <= fp_error_out;
      end
   end
endmodule

// ### tb/tb_fpu_exception_reporting.sv
// Self-checking bench of the floating-point exception unit
`timescale 1ns/1ns

module tb_fpu_exception_reporting;
   import fpu_exc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr, fault_vector;
   logic [31:0] pwdata, prdata, issue_prefix_ip, rd;
   logic [15:0] issue_cs;
   logic [2:0]  done_quotient;
   logic [1:0]  cpl;
   logic        task_switched_flag, emulation_flag, align_check_en, v86_mode, issue_valid;
   logic        issue_legal, issue_misaligned, issue_stack_part, issue_beyond_limit;
   logic        issue_seg_overrun, issue_denormal, issue_ready, exec_go, normalize_req;
   logic        rem_round_nearest, fault_valid, abort_out, env_probe_req, env_probe_last;
   logic        env_probe_ack, env_probe_fault, env_commit, done_valid, done_unmasked_exc;
   logic        done_inexact, done_underflow, done_uflow_loss, done_second_frac;
   logic        res_invalid, res_underflow, res_precision, scale_factor_zero;
   logic        cond_flag_zero, cond_flag_one, cond_flag_three, ignore_numeric_error_in;
   logic        fp_error_out, maskable_irq_in;
   op_kind_t    issue_kind;
   int          mismatches, checks_done;

   fpu_exception_reporting fpu_exception_reporting_i (.*);
   irq_controller_model    irq_controller_model_i (.*);

   // ==========================================================
   // Clock, 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ==========================================================
   // Shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   // APB transfer; waits on pready, only the watchdog ends a dead wait
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      chk(n, 1, "pready wait");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, "register read");
   endtask

   // f = {ts, em, user, misaligned, stack, beyond, overrun, denormal}
   // ev: vector, FF execute, FE abort, FD probe start
   task automatic iss(input op_kind_t k, input logic lg, input logic [7:0] f,
                      input logic [7:0] ev);
      @(posedge pclk);
      issue_valid <= 1'b1;
      issue_kind <= k;
      issue_legal <= lg;
      {task_switched_flag, emulation_flag} <= f[7:6];
      cpl <= f[5] ? CPL_USER : 2'h0;
      {issue_misaligned, issue_stack_part, issue_beyond_limit} <= f[4:2];
      {issue_seg_overrun, issue_denormal} <= f[1:0];
      @(posedge pclk);
      issue_valid <= 1'b0;
      #1;
      if (ev == 8'hFF) chk({exec_go, fault_valid}, 2'b10, "go");
      else if (ev == 8'hFE) chk({abort_out, fault_valid}, 2'b10, "abort");
      else if (ev == 8'hFD) chk({env_probe_req, env_probe_last}, 2'b10, "probe");
      else chk({fault_valid, fault_vector}, {1'b1, ev}, "fault");
   endtask

   // f = {unmasked, inexact, underflow, loss, second_frac}
   task automatic fin(input logic [4:0] f, input logic [2:0] q);
      @(posedge pclk);
      done_valid <= 1'b1;
      {done_unmasked_exc, done_inexact, done_underflow} <= f[4:2];
      {done_uflow_loss, done_second_frac} <= f[1:0];
      done_quotient <= q;
      @(posedge pclk);
      done_valid <= 1'b0;
      #1;
   endtask

   task automatic ack;
      @(posedge pclk);
      env_probe_ack <= 1'b1;
      @(posedge pclk);
      env_probe_ack <= 1'b0;
      #1;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the 150 or so cycles the tests need
   initial begin
      #100000;
      mismatches++;
      final_report();
   end

   // ==========================================================
   // Test sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, issue_valid, issue_legal} = '0;
      {task_switched_flag, emulation_flag, cpl, v86_mode, issue_misaligned} = '0;
      {issue_stack_part, issue_beyond_limit, issue_seg_overrun, issue_denormal} = '0;
      {env_probe_ack, env_probe_fault, done_valid, done_unmasked_exc, done_inexact} = '0;
      {done_underflow, done_uflow_loss, done_second_frac, done_quotient} = '0;
      {ignore_numeric_error_in, mismatches, checks_done} = '0;
      issue_kind = OP_OTHER;
      align_check_en = 1'b1;
      issue_cs = 16'h0123;
      issue_prefix_ip = 32'h0000_4A10;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdchk(OFS_CTRL, CTRL_RESET);
      rdchk(OFS_STATUS, 32'h0000_0000);
      rdchk(OFS_MASK, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk(err, 1, "unmapped");
      apb(1'b1, OFS_CTRL, 32'h0000_1001);
      iss(OP_OTHER, 1'b0, 8'h80, VEC_DEVICE_NA);
      iss(OP_DIV, 1'b1, 8'h40, VEC_DEVICE_NA);
      iss(OP_OTHER, 1'b0, 8'h00, VEC_INVALID_OPCODE);
      iss(OP_OTHER, 1'b1, 8'h04, VEC_GEN_PROT);
      iss(OP_OTHER, 1'b1, 8'h30, VEC_ALIGN_CHECK);
      iss(OP_OTHER, 1'b1, 8'h38, 8'hFF);
      iss(OP_OTHER, 1'b1, 8'h10, 8'hFF);
      iss(OP_OTHER, 1'b1, 8'h02, 8'hFE);
      // Denormal operand on every normalising class
      for (int k = 1; k <= 5; k++) begin
         iss(op_kind_t'(k), 1'b1, 8'h01, 8'hFF);
         chk(normalize_req, 1, "normalize");
         chk(rem_round_nearest, k == 4, "rounding");
         fin(5'b00100, 3'h0);
         chk(res_invalid, 0, "invalid");
         chk(res_underflow, 1, "underflow");
      end
      iss(OP_PREM, 1'b1, 8'h00, 8'hFF);
      for (int q = 0; q < 8; q++) begin
         fin(5'b00000, q[2:0]);
         chk({cond_flag_zero, cond_flag_three, cond_flag_one}, q, "quotient");
      end
      iss(OP_SCALE, 1'b1, 8'h00, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         fin({1'b0, i == 0, 1'b0, i == 1, i != 2}, 3'h0);
         chk(scale_factor_zero, i != 2, "scale zero");
         chk(res_precision, i < 2, "precision");
      end
      // Unmasked exception raises the pin, then blocks the next instruction
      iss(OP_SQRT, 1'b1, 8'h00, 8'hFF);
      fin(5'b10000, 3'h0);
      @(posedge pclk);
      #1;
      chk(fp_error_out, 1, "error pin");
      @(posedge pclk);
      #1;
      chk(maskable_irq_in, 1, "controller");
      rdchk(OFS_SAVED_IP, 32'h0000_4A10);
      rdchk(OFS_SAVED_CS, 32'h0000_0123);
      chk(irq, 0, "masked irq");
      iss(OP_OTHER, 1'b1, 8'h00, VEC_FP_ERROR);
      iss(OP_OTHER, 1'b0, 8'h00, VEC_INVALID_OPCODE);
      apb(1'b1, OFS_CTRL, 32'h0000_2201);
      v86_mode <= 1'b1;
      iss(OP_OTHER, 1'b1, 8'h00, 8'h22);
      @(posedge pclk);
      v86_mode <= 1'b0;
      ignore_numeric_error_in <= 1'b1;
      repeat (3) @(posedge pclk);
      iss(OP_OTHER, 1'b1, 8'h00, 8'hFF);
      @(posedge pclk);
      ignore_numeric_error_in <= 1'b0;
      apb(1'b1, OFS_MASK, 32'h0000_0001);
      @(posedge pclk);
      #1;
      chk({irq, fp_error_out}, 2'b11, "irq and pin held");
      apb(1'b1, OFS_STATUS, 32'h0000_007F);
      repeat (3) @(posedge pclk);
      #1;
      chk({irq, fp_error_out}, 2'b00, "pin cleared");
      rdchk(OFS_STATUS, 32'h0000_0000);
      iss(OP_OTHER, 1'b1, 8'h00, 8'hFF);
      // Environment load probes both ends before committing
      iss(OP_LDENV, 1'b1, 8'h00, 8'hFD);
      chk(issue_ready, 0, "busy");
      ack();
      // Request drops for the cycle after the first answer
      @(posedge pclk);
      #1;
      chk({env_probe_req, env_probe_last, env_commit}, 3'b110, "last probe");
      ack();
      chk(env_commit, 1, "commit");
      // A faulting probe aborts with nothing committed
      iss(OP_LDENV, 1'b1, 8'h00, 8'hFD);
      @(posedge pclk);
      env_probe_fault <= 1'b1;
      @(posedge pclk);
      env_probe_fault <= 1'b0;
      #1;
      chk({abort_out, env_commit, issue_ready}, 3'b101, "probe fault");
      final_report();
   end
endmodule
